//--- src/pcp_parallel_config_port.v
// parallel configuration and readback port of the device
//
// What this block does
// - bidirectional data bus, 8, 16 or 32 bits
// - bus width found without any select pin
// - master drives cfgClock, slave receives it
// - words move on cfgClock rising edge
// - configuration mode taken from modeSel pins
// - busy shows readback data not ready
// - done low until configured, then released
// - init input held low delays configuration
// - init then open-drain low on crc error
// - upset crc error pulls init low if enabled
// - full reset pin resets asynchronously
// - port select low enables data bus
// - direction low inputs, high outputs
// - direction change while selected causes abort
// - chain select output enables next device
`timescale 1ns/100ps
`include "pcp_defines.vh"
module pcp_parallel_config_port #(
  parameter CLK_HALF = `PCP_CLK_HALF
) (
  // clock and reset
  input  wire        ref_clk,
  input  wire        rst,
  // reset and mode pins
  input  wire        fullResetN,
  input  wire [2:0]  modeSel,
  // configuration clock pin
  input  wire        cfgClockI,
  output wire        cfgClockO,
  output wire        cfgClockOe,
  // data bus pins
  input  wire [31:0] dataI,
  output wire [31:0] dataO,
  output wire [31:0] dataOe,
  // bus control pins
  input  wire        portSelectN,
  input  wire        directionSelect,
  output wire        busyO,
  output wire        busyOe,
  // status pins
  output wire        doneO,
  output wire        doneOe,
  input  wire        initI,
  output wire        initO,
  output wire        initOe,
  output wire        chainSelectOutN,
  // configuration engine side
  input  wire        chainEnable,
  input  wire        cfgComplete,
  input  wire        crcError,
  input  wire        seuEnable,
  input  wire        seuOnInit,
  input  wire        seuCrcError,
  input  wire [31:0] rbWord,
  input  wire        rbWordValid,
  output wire        rbWordTaken,
  output wire [31:0] cfgWord,
  output wire        cfgWordValid,
  output wire [1:0]  busWidth,
  output wire        widthKnown,
  output wire [2:0]  modeLatched,
  output wire        configured,
  output wire        abortActive
);

  // -------------------------------------------------------------
  // states
  // -------------------------------------------------------------
  localparam [4:0] ST_INIT  = 5'b00001;
  localparam [4:0] ST_LOAD  = 5'b00010;
  localparam [4:0] ST_DONE  = 5'b00100;
  localparam [4:0] ST_ABORT = 5'b01000;
  localparam [4:0] ST_HOLD  = 5'b10000;

  // -------------------------------------------------------------
  // decoding helpers
  // -------------------------------------------------------------
  function [31:0] laneMask;
    input [1:0] width;
    begin
      case (width)
        `PCP_W8:  laneMask = `PCP_MASK8;
        `PCP_W16: laneMask = `PCP_MASK16;
        default:  laneMask = `PCP_MASK32;
      endcase
    end
  endfunction

  function [1:0] detectWidth;
    input [31:0] word;
    begin
      if (word == `PCP_PAT32)
        detectWidth = `PCP_W32;
      else if (word[15:0] == `PCP_PAT16)
        detectWidth = `PCP_W16;
      else
        detectWidth = `PCP_W8;
    end
  endfunction

  // -------------------------------------------------------------
  // reset and pin synchronisation
  // -------------------------------------------------------------
  // the full reset pin clears everything without waiting for a clock
  wire coreRst = rst | ~fullResetN;

  wire [`PCP_SYNC_W-1:0] syncLevel;
  wire [31:0]            dataS;
  wire                   cfgClockS;
  wire                   portSelectNS;
  wire                   directionS;
  wire                   initS;
  wire [2:0]             modeS;

  pcp_sync #(
    .WIDTH     (`PCP_SYNC_W),
    .RESET_VAL (`PCP_SYNC_RST)
  ) u_sync (
    .ref_clk  (ref_clk),
    .rst      (coreRst),
    .pinIn    ({dataI, cfgClockI, portSelectN, directionSelect, initI, modeSel}),
    .levelOut (syncLevel)
  );

  assign {dataS, cfgClockS, portSelectNS, directionS, initS, modeS} = syncLevel;

  // -------------------------------------------------------------
  // state registers
  // -------------------------------------------------------------
  reg [4:0]              state_q;
  reg [4:0]              resume_q;
  reg [2:0]              mode_q;
  reg                    modeSampled_q;
  reg                    clkPrev_q;
  reg [`PCP_SYNC_LAT-1:0] riseDly_q;
  reg                    dirPrev_q;
  reg                    keySeen_q;
  reg                    widthKnown_q;
  reg [1:0]              width_q;
  reg [31:0]             cfgWord_q;
  reg                    cfgWordValid_q;
  reg [31:0]             dataO_q;
  reg                    busy_q;
  reg                    rbTaken_q;
  reg                    configured_q;
  reg                    initFault_q;
  reg                    chainSelN_q;

  // -------------------------------------------------------------
  // configuration clock
  // -------------------------------------------------------------
  wire isMaster  = modeSampled_q & (mode_q == `PCP_MODE_MASTER);
  wire clkRun    = isMaster & (state_q != ST_HOLD);
  wire masterRise;

  // master mode makes its own clock and drives the pin
  pcp_clk_div #(
    .HALF (CLK_HALF)
  ) u_clk_div (
    .ref_clk   (ref_clk),
    .rst       (coreRst),
    .run       (clkRun),
    .clkOut    (cfgClockO),
    .risePulse (masterRise)
  );

  assign cfgClockOe = clkRun;

  // the master edge is delayed to line up with the synchronised data
  wire slaveRise = cfgClockS & ~clkPrev_q;
  wire linkRise  = isMaster ? riseDly_q[`PCP_SYNC_LAT-1] : slaveRise;

  // -------------------------------------------------------------
  // bus qualification
  // -------------------------------------------------------------
  wire selected   = ~portSelectNS;
  wire busState   = (state_q == ST_LOAD) | (state_q == ST_DONE);
  wire busActive  = selected & busState;
  wire writeEdge  = linkRise & busActive & ~directionS;
  wire readEdge   = linkRise & busActive & directionS;
  wire dirFlip    = selected & busState & (directionS != dirPrev_q);
  wire seuHit     = seuEnable & seuOnInit & seuCrcError;
  wire [31:0] mask = laneMask(width_q);

  // -------------------------------------------------------------
  // control sequence
  // -------------------------------------------------------------
  always @(posedge ref_clk or posedge coreRst) begin
    if (coreRst) begin
      state_q       <= ST_INIT;
      resume_q      <= ST_LOAD;
      mode_q        <= 3'h0;
      modeSampled_q <= 1'b0;
      clkPrev_q     <= 1'b0;
      riseDly_q     <= {`PCP_SYNC_LAT{1'b0}};
      dirPrev_q     <= 1'b0;
      configured_q  <= 1'b0;
      initFault_q   <= 1'b0;
      chainSelN_q   <= 1'b1;
    end else begin
      clkPrev_q   <= cfgClockS;
      riseDly_q   <= {riseDly_q[`PCP_SYNC_LAT-2:0], masterRise};
      dirPrev_q   <= directionS;
      chainSelN_q <= ~(configured_q & chainEnable);
      if (modeSampled_q && (((state_q == ST_LOAD) && crcError) || seuHit)) begin
        initFault_q <= 1'b1;
      end
      case (state_q)
        ST_INIT: begin
          // an outside party holding init low keeps us here
          if (initS) begin
            mode_q        <= modeS;
            modeSampled_q <= 1'b1;
            if ((modeS == `PCP_MODE_MASTER) || (modeS == `PCP_MODE_SLAVE)) begin
              state_q <= ST_LOAD;
            end else begin
              state_q <= ST_HOLD;
            end
          end
        end
        ST_LOAD: begin
          if (dirFlip) begin
            resume_q <= ST_LOAD;
            state_q  <= ST_ABORT;
          end else if (cfgComplete) begin
            configured_q <= 1'b1;
            state_q      <= ST_DONE;
          end
        end
        ST_DONE: begin
          if (dirFlip) begin
            resume_q <= ST_DONE;
            state_q  <= ST_ABORT;
          end
        end
        ST_ABORT: begin
          // abort ends only once the port is deselected
          if (!selected) begin
            state_q <= resume_q;
          end
        end
        ST_HOLD: begin
          state_q <= ST_HOLD;
        end
        default: begin
          state_q <= ST_INIT;
        end
      endcase
    end
  end

  // -------------------------------------------------------------
  // configuration write path and width detection
  // -------------------------------------------------------------
  always @(posedge ref_clk or posedge coreRst) begin
    if (coreRst) begin
      keySeen_q      <= 1'b0;
      widthKnown_q   <= 1'b0;
      width_q        <= `PCP_W8;
      cfgWord_q      <= `PCP_ZERO32;
      cfgWordValid_q <= 1'b0;
    end else begin
      cfgWordValid_q <= 1'b0;
      if (writeEdge && (state_q == ST_LOAD)) begin
        if (!widthKnown_q) begin
          // the key byte on the low lane precedes the width pattern
          if (!keySeen_q) begin
            keySeen_q <= (dataS[7:0] == `PCP_KEY8);
          end else if (dataS[7:0] == `PCP_PAT8 || dataS[15:0] == `PCP_PAT16 ||
                       dataS == `PCP_PAT32) begin
            width_q      <= detectWidth(dataS);
            widthKnown_q <= 1'b1;
          end else begin
            keySeen_q <= (dataS[7:0] == `PCP_KEY8);
          end
        end else begin
          cfgWord_q      <= dataS & mask;
          cfgWordValid_q <= 1'b1;
        end
      end
    end
  end

  // -------------------------------------------------------------
  // readback path
  // -------------------------------------------------------------
  always @(posedge ref_clk or posedge coreRst) begin
    if (coreRst) begin
      dataO_q   <= `PCP_ZERO32;
      busy_q    <= 1'b0;
      rbTaken_q <= 1'b0;
    end else begin
      rbTaken_q <= 1'b0;
      if (readEdge && (state_q == ST_DONE)) begin
        if (rbWordValid) begin
          dataO_q   <= rbWord & mask;
          busy_q    <= 1'b0;
          rbTaken_q <= 1'b1;
        end else begin
          busy_q <= 1'b1;
        end
      end else if (!busActive || !directionS) begin
        // loading never stalls, so busy stays low outside readback
        busy_q <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------
  // pin drive
  // -------------------------------------------------------------
  // drivers only turn on for readback on a selected port
  assign dataOe = (busActive && directionS && (state_q == ST_DONE)) ? mask
                                                                    : `PCP_ZERO32;
  assign dataO  = dataO_q;
  assign busyO  = busy_q;
  assign busyOe = selected & modeSampled_q;
  assign doneO  = 1'b0;
  assign doneOe = ~configured_q;
  assign initO  = 1'b0;
  assign initOe = modeSampled_q & initFault_q;

  assign chainSelectOutN = chainSelN_q;

  // -------------------------------------------------------------
  // engine side outputs
  // -------------------------------------------------------------
  assign cfgWord      = cfgWord_q;
  assign cfgWordValid = cfgWordValid_q;
  assign rbWordTaken  = rbTaken_q;
  assign busWidth     = width_q;
  assign widthKnown   = widthKnown_q;
  assign modeLatched  = mode_q;
  assign configured   = configured_q;
  assign abortActive  = (state_q == ST_ABORT);

endmodule // pcp_parallel_config_port

//--- src/pcp_defines.vh
// constants shared by the parallel configuration port files
`ifndef PCP_DEFINES_VH
`define PCP_DEFINES_VH

// ---------------------------------------------------------------
// mode select codes
// ---------------------------------------------------------------
`define PCP_MODE_MASTER   3'h2
`define PCP_MODE_SLAVE    3'h6

// ---------------------------------------------------------------
// bus width codes and lane masks
// ---------------------------------------------------------------
`define PCP_W8            2'h0
`define PCP_W16           2'h1
`define PCP_W32           2'h2
`define PCP_MASK8         32'h0000_00FF
`define PCP_MASK16        32'h0000_FFFF
`define PCP_MASK32        32'hFFFF_FFFF
`define PCP_ZERO32        32'h0000_0000

// ---------------------------------------------------------------
// width detection words
// ---------------------------------------------------------------
`define PCP_KEY8          8'hBB
`define PCP_PAT8          8'h11
`define PCP_PAT16         16'h1122
`define PCP_PAT32         32'h1122_0044

// ---------------------------------------------------------------
// timing and reset values
// ---------------------------------------------------------------
`define PCP_CLK_HALF      4
`define PCP_SYNC_LAT      4
`define PCP_SYNC_W        39
`define PCP_SYNC_RST      39'h00_0000_0020
`define PCP_CNT_W         8

`endif

//--- src/pcp_sync.v
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module pcp_sync #(
  parameter WIDTH     = 1,
  parameter RESET_VAL = {WIDTH{1'b0}}
) (
  // clock and reset
  input  wire             ref_clk,
  input  wire             rst,
  // pins in, agreed levels out
  input  wire [WIDTH-1:0] pinIn,
  output wire [WIDTH-1:0] levelOut
);

  reg [WIDTH-1:0] stage1_q;
  reg [WIDTH-1:0] stage2_q;
  reg [WIDTH-1:0] stage3_q;
  reg [WIDTH-1:0] level_q;

  // a bit moves only once stages two and three agree
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stage1_q <= RESET_VAL;
      stage2_q <= RESET_VAL;
      stage3_q <= RESET_VAL;
      level_q  <= RESET_VAL;
    end else begin
      stage1_q <= pinIn;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
      level_q  <= (stage2_q & stage3_q) | (level_q & (stage2_q | stage3_q));
    end
  end

  assign levelOut = level_q;

endmodule // pcp_sync

//--- src/pcp_clk_div.v
// divider that makes the outgoing configuration clock in master mode
`timescale 1ns/100ps
`include "pcp_defines.vh"
module pcp_clk_div #(
  parameter HALF = `PCP_CLK_HALF
) (
  // clock and reset
  input  wire ref_clk,
  input  wire rst,
  // control and clock out
  input  wire run,
  output wire clkOut,
  output wire risePulse
);

  reg [`PCP_CNT_W-1:0] count_q;
  reg                  clk_q;
  reg                  rise_q;

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_q <= {`PCP_CNT_W{1'b0}};
      clk_q   <= 1'b0;
      rise_q  <= 1'b0;
    end else begin
      rise_q <= 1'b0;
      if (!run) begin
        count_q <= {`PCP_CNT_W{1'b0}};
        clk_q   <= 1'b0;
      end else if (count_q == HALF[`PCP_CNT_W-1:0] - 1'b1) begin
        count_q <= {`PCP_CNT_W{1'b0}};
        clk_q   <= ~clk_q;
        rise_q  <= ~clk_q;
      end else begin
        count_q <= count_q + 1'b1;
      end
    end
  end

  assign clkOut    = clk_q;
  assign risePulse = rise_q;

endmodule // pcp_clk_div

//--- verification/pcp_port_assertions.sv
// pin-level assertions for the parallel configuration port
`timescale 1ns/100ps
`include "pcp_defines.vh"
module pcp_port_assertions (
  input wire        ref_clk,
  input wire        rst,
  input wire        fullResetN,
  input wire        portSelectN,
  input wire        chainEnable,
  input wire        seuEnable,
  input wire        seuOnInit,
  input wire        seuCrcError,
  input wire        cfgClockOe,
  input wire [31:0] dataOe,
  input wire        busyO,
  input wire        doneOe,
  input wire        initOe,
  input wire        chainSelectOutN,
  input wire        rbWordTaken,
  input wire        cfgWordValid,
  input wire [1:0]  busWidth,
  input wire        widthKnown,
  input wire [2:0]  modeLatched,
  input wire        configured
);
  // ----------------------------------------
  // checks
  // ----------------------------------------
  wire [31:0] laneMask = (busWidth == `PCP_W8) ? `PCP_MASK8 :
                         (busWidth == `PCP_W16) ? `PCP_MASK16 : `PCP_MASK32;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst || !fullResetN);
  a_lane_width: assert property (dataOe != 0 |-> widthKnown && dataOe == laneMask)
    else $error("data enables do not match the found width");
  a_word_spacing: assert property (cfgWordValid |=> !cfgWordValid [*6])
    else $error("write words closer than one link clock");
  a_read_ready: assert property (rbWordTaken |-> !busyO ##1 !rbWordTaken [*6])
    else $error("busy high while a read word is handed out");
  a_done_state: assert property (doneOe != configured)
    else $error("done pin drive disagrees with configured");
  a_init_sticky: assert property (initOe |=> initOe)
    else $error("init fault released without reset");
  a_upset_init: assert property (seuEnable && seuOnInit && seuCrcError |=> initOe)
    else $error("upset error did not pull init low");
  a_chain_sel: assert property (!chainSelectOutN |-> $past(configured) && $past(chainEnable))
    else $error("chain select low without cause");
  a_clk_master: assert property (cfgClockOe |-> modeLatched == `PCP_MODE_MASTER)
    else $error("config clock driven outside master mode");
  a_desel_quiet: assert property (portSelectN [*8] |-> dataOe == 0 && !cfgWordValid)
    else $error("deselected port active on the bus");
  cover property (cfgWordValid);
  cover property (rbWordTaken);
  cover property ($rose(initOe));
endmodule // pcp_port_assertions

bind pcp_parallel_config_port pcp_port_assertions u_chk (.ref_clk(ref_clk), .rst(rst),
  .fullResetN(fullResetN), .portSelectN(portSelectN), .chainEnable(chainEnable),
  .seuEnable(seuEnable), .seuOnInit(seuOnInit), .seuCrcError(seuCrcError),
  .cfgClockOe(cfgClockOe), .dataOe(dataOe), .busyO(busyO), .doneOe(doneOe), .initOe(initOe),
  .chainSelectOutN(chainSelectOutN), .rbWordTaken(rbWordTaken), .cfgWordValid(cfgWordValid),
  .busWidth(busWidth), .widthKnown(widthKnown), .modeLatched(modeLatched),
  .configured(configured));

//--- verification/pcp_cfg_host_model.sv
// host controller model driving the port in slave mode
`timescale 1ns/100ps
module pcp_cfg_host_model (
  input  wire [31:0] dataBus,
  output reg         hostClk,
  output reg  [31:0] hostData
);
  // ----------------------------------------
  // one 80 ns link clock period per written word, 120 ns per read word
  // ----------------------------------------
  // odd offsets keep the link clock off the ref_clk edges
  initial begin
    hostClk = 1'h0;
    hostData = 32'h0000_0000;
  end
  task writeWord(input [31:0] w);
    begin
      #23 hostData = w;
      #17 hostClk = 1'h1;
      #40 hostClk = 1'h0;
    end
  endtask
  // bus released: no pull, so show the inverse of the last value
  task readWord(output [31:0] w);
    begin
      #23 hostData = ~hostData;
      #17 hostClk = 1'h1;
      #40 hostClk = 1'h0;
      #40 w = dataBus;
    end
  endtask
endmodule // pcp_cfg_host_model

//--- verification/pcp_parallel_config_port_tb.sv
// self-checking bench for the parallel configuration port
`timescale 1ns/100ps
`include "pcp_defines.vh"
module pcp_parallel_config_port_tb;
  reg         ref_clk = 1'h0;
  reg         rst = 1'h1;
  reg         fullResetN = 1'h1;
  reg  [2:0]  modeSel = `PCP_MODE_SLAVE;
  reg         portSelectN = 1'h0;
  reg         directionSelect = 1'h0;
  reg         hostInitLow = 1'h1;
  reg         chainEnable = 1'h0;
  reg         cfgComplete = 1'h0;
  reg         crcError = 1'h0;
  reg         seuEnable = 1'h0;
  reg         seuOnInit = 1'h0;
  reg         seuCrcError = 1'h0;
  reg  [31:0] rbWord = 32'h0000_0000;
  reg         rbWordValid = 1'h0;
  reg  [31:0] lastCfg = 32'h0000_0000;
  reg  [31:0] got;
  reg         prev;
  integer     nValid = 0;
  integer     nTaken = 0;
  integer     n;
  integer     num_errors = 0;
  integer     compares = 0;
  integer     cycles = 0;
  wire [31:0] dataO, dataOe, hostData, cfgWord;
  wire [1:0]  busWidth;
  wire [2:0]  modeLatched;
  wire        hostClk, cfgClockO, cfgClockOe, busyO, busyOe, doneO, doneOe, initO, initOe;
  wire        chainSelectOutN, rbWordTaken, cfgWordValid, widthKnown, configured, abortActive;
  wire        cfgClockI = cfgClockOe ? cfgClockO : hostClk;
  wire [31:0] dataBus = (dataOe & dataO) | (~dataOe & hostData);
  // both status pins are open drain with a pull-up on the board
  wire        initWire = (initOe ? initO : 1'h1) & ~hostInitLow;
  wire        doneWire = doneOe ? doneO : 1'h1;
  // ----------------------------------------
  // design, host and clock
  // ----------------------------------------
  pcp_parallel_config_port #(.CLK_HALF(4)) DUT (.ref_clk(ref_clk), .rst(rst),
    .fullResetN(fullResetN), .modeSel(modeSel), .cfgClockI(cfgClockI), .cfgClockO(cfgClockO),
    .cfgClockOe(cfgClockOe), .dataI(dataBus), .dataO(dataO), .dataOe(dataOe),
    .portSelectN(portSelectN), .directionSelect(directionSelect), .busyO(busyO),
    .busyOe(busyOe), .doneO(doneO), .doneOe(doneOe), .initI(initWire), .initO(initO),
    .initOe(initOe), .chainSelectOutN(chainSelectOutN), .chainEnable(chainEnable),
    .cfgComplete(cfgComplete), .crcError(crcError), .seuEnable(seuEnable),
    .seuOnInit(seuOnInit), .seuCrcError(seuCrcError), .rbWord(rbWord),
    .rbWordValid(rbWordValid), .rbWordTaken(rbWordTaken), .cfgWord(cfgWord),
    .cfgWordValid(cfgWordValid), .busWidth(busWidth), .widthKnown(widthKnown),
    .modeLatched(modeLatched), .configured(configured), .abortActive(abortActive));
  pcp_cfg_host_model HOST (.dataBus(dataBus), .hostClk(hostClk), .hostData(hostData));
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (cfgWordValid === 1'h1) begin
      lastCfg <= cfgWord;
      nValid <= nValid + 1;
    end
    if (rbWordTaken === 1'h1)
      nTaken <= nTaken + 1;
    cycles = cycles + 1;
    if (cycles == 8000) begin
      num_errors = num_errors + 1;
      tally_and_finish;
    end
  end
  task chk(input [8*10:1] what, input [31:0] exp, input [31:0] seen);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("unexpected %0s: expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task waitc(input integer k);
    begin
      repeat (k) @(posedge ref_clk);
      #1;
    end
  endtask
  task setSel(input v);
    begin
      @(posedge ref_clk) portSelectN <= v;
      waitc(10);
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_init;
    begin
      waitc(30);
      chk("busyOe", 0, busyOe);
      @(posedge ref_clk) hostInitLow <= 1'h0;
      waitc(20);
      chk("mode", `PCP_MODE_SLAVE, modeLatched);
      chk("busyOe", 1, busyOe);
      chk("clkOe", 0, cfgClockOe);
    end
  endtask
  task t_width;
    begin
      HOST.writeWord(32'h0000_00BB);
      HOST.writeWord(32'h0000_1122);
      waitc(8);
      chk("known", 1, widthKnown);
      chk("width", `PCP_W16, busWidth);
      HOST.writeWord(32'hA5A5_C3C3);
      waitc(8);
      chk("cfgWord", 32'h0000_C3C3, lastCfg);
      n = nValid;
      setSel(1'h1);
      HOST.writeWord(32'h5A5A_3C3C);
      waitc(8);
      chk("ignored", n, nValid);
      setSel(1'h0);
    end
  endtask
  task t_abort;
    begin
      @(posedge ref_clk) directionSelect <= 1'h1;
      waitc(10);
      chk("abort", 1, abortActive);
      setSel(1'h1);
      chk("abort", 0, abortActive);
      @(posedge ref_clk) directionSelect <= 1'h0;
      waitc(10);
      setSel(1'h0);
    end
  endtask
  task t_crc;
    begin
      chk("initPin", 1, initWire);
      chk("donePin", 0, doneWire);
      @(posedge ref_clk) crcError <= 1'h1;
      @(posedge ref_clk) crcError <= 1'h0;
      waitc(2);
      chk("initPin", 0, initWire);
    end
  endtask
  task t_read;
    begin
      @(posedge ref_clk) cfgComplete <= 1'h1;
      @(posedge ref_clk) cfgComplete <= 1'h0;
      chainEnable <= 1'h1;
      waitc(3);
      chk("donePin", 1, doneWire);
      chk("configured", 1, configured);
      chk("chainSel", 0, chainSelectOutN);
      setSel(1'h1);
      @(posedge ref_clk) directionSelect <= 1'h1;
      waitc(10);
      setSel(1'h0);
      HOST.readWord(got);
      chk("busy", 1, busyO);
      @(posedge ref_clk) rbWord <= 32'h1234_5678;
      rbWordValid <= 1'h1;
      // step off the edge so the link clock never moves with ref_clk
      waitc(1);
      HOST.readWord(got);
      // only the x16 lanes are driven, the upper ones float on the host side
      chk("rdData", 32'h0000_5678, got & `PCP_MASK16);
      chk("dataO", 32'h0000_5678, dataO);
      chk("taken", 1, nTaken);
      chk("dataOe", `PCP_MASK16, dataOe);
      chk("busy", 0, busyO);
    end
  endtask
  task fullReset(input [2:0] m);
    begin
      @(posedge ref_clk) fullResetN <= 1'h0;
      modeSel <= m;
      directionSelect <= 1'h0;
      rbWordValid <= 1'h0;
      #3;
      chk("doneOe", 1, doneOe);
      chk("initOe", 0, initOe);
      @(posedge ref_clk) fullResetN <= 1'h1;
      waitc(20);
    end
  endtask
  task t_seu;
    begin
      fullReset(`PCP_MODE_SLAVE);
      HOST.writeWord(32'h0000_00BB);
      HOST.writeWord(32'h1122_0044);
      HOST.writeWord(32'hA5A5_C3C3);
      waitc(8);
      chk("width", `PCP_W32, busWidth);
      chk("cfgWord", 32'hA5A5_C3C3, lastCfg);
      @(posedge ref_clk) seuEnable <= 1'h1;
      seuCrcError <= 1'h1;
      @(posedge ref_clk) seuCrcError <= 1'h0;
      waitc(3);
      chk("initOe", 0, initOe);
      @(posedge ref_clk) seuOnInit <= 1'h1;
      seuCrcError <= 1'h1;
      @(posedge ref_clk) seuCrcError <= 1'h0;
      waitc(3);
      chk("initOe", 1, initOe);
    end
  endtask
  task t_master;
    begin
      // an unknown mode code parks the port with no clock
      fullReset(3'h1);
      chk("mode", 3'h1, modeLatched);
      chk("clkOe", 0, cfgClockOe);
      fullReset(`PCP_MODE_MASTER);
      n = 0;
      prev = cfgClockO;
      repeat (80) begin
        waitc(1);
        if (cfgClockO === 1'h1 && prev === 1'h0)
          n = n + 1;
        prev = cfgClockO;
      end
      chk("clkOe", 1, cfgClockOe);
      chk("clkRises", 80 / 8, n);
    end
  endtask
  task tally_and_finish;
    begin
      $display("compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'h0;
    t_init;
    t_width;
    t_abort;
    t_crc;
    t_read;
    t_seu;
    t_master;
    tally_and_finish;
  end
endmodule // pcp_parallel_config_port_tb
